//--- design/sem_params.svh
// register map, reset values and limits of the shared lock block
`ifndef SEM_PARAMS_SVH
`define SEM_PARAMS_SVH

// --------------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// --------------------------------------------------------------------
`define SEM_ADDR_W        8
`define SEM_OFS_CLAIM0    8'h00
`define SEM_OFS_HOLD0     8'h04
`define SEM_OFS_CLAIM1    8'h08
`define SEM_OFS_HOLD1     8'h0c
`define SEM_OFS_POL       8'h10
`define SEM_OFS_IRQ_STAT  8'h14
`define SEM_OFS_IRQ_MASK  8'h18

// --------------------------------------------------------------------
// reset values and sizes
// --------------------------------------------------------------------
`define SEM_CLAIM_FREE    1'b1
`define SEM_HOLD_RST      32'h0000_0000
`define SEM_POL_RST       2'h0
`define SEM_MASK_RST      2'h0
`define SEM_STAT_RST      2'h0
`define SEM_DATA_W        32
`define SEM_NUM_LOCKS     2
`define SEM_IF_MIN        2
`define SEM_IF_MAX        32

`endif

//--- design/sem_pkg.sv
// types shared by the lock block
package sem_pkg;

  // one bit per lock: polarity, status and mask all use this layout
  typedef logic [1:0] sem_lock_vec_t;

  // a full bus word
  typedef logic [31:0] sem_word_t;

endpackage : sem_pkg

//--- design/sem_core.sv
// two hardware locks shared by several register-access interfaces
`timescale 1ns/1ns
`default_nettype none
`include "sem_params.svh"

module sem_core
  import sem_pkg::*;
#(
  parameter int N_IF = 4
)
(
  input  wire logic                                   clk,
  input  wire logic                                   rst_n,
  input  wire logic [N_IF-1:0][`SEM_ADDR_W-1:0]       bus_addr,
  input  wire logic [N_IF-1:0][`SEM_DATA_W-1:0]       bus_wdata,
  input  wire logic [N_IF-1:0]                        bus_wr,
  input  wire logic [N_IF-1:0]                        bus_rd,
  output var  logic [N_IF-1:0][`SEM_DATA_W-1:0]       bus_rdata,
  output var  logic                                   irq
);

  // ------------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------------
  // holder words are 32 bits wide, so no more than 32 interfaces fit
  if (N_IF < `SEM_IF_MIN || N_IF > `SEM_IF_MAX)
  begin : g_bad_nif
    $error("sem_core: N_IF must lie between 2 and 32");
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  // register map seen by every interface (byte offsets):
  //   claim zero, holder zero, claim one, holder one,
  //   interrupt polarity, interrupt status (write one to clear),
  //   interrupt mask; every other offset reads zero
  // each holder word keeps one bit per interface, so a free lock is
  // simply an all-zero holder and needs no separate flag
  // read data are kept per interface so that all of them can be
  // answered in the same cycle without any arbitration delay
  typedef struct packed {
    logic [N_IF-1:0][`SEM_DATA_W-1:0] rdata;
    logic [1:0][N_IF-1:0]             holder;
    sem_lock_vec_t                    pol;
    sem_lock_vec_t                    stat;
    sem_lock_vec_t                    mask;
    logic                             irq;
  } sem_state_s;

  sem_state_s s_r;
  sem_state_s s_nxt;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  // all interfaces are decoded in the same cycle; a read never waits
  always_comb
  begin
    logic [1:0][N_IF-1:0] rd_req;
    logic [1:0][N_IF-1:0] win;
    logic [1:0]           wr_hit;
    logic [1:0]           taken;
    logic [1:0]           cond;
    sem_lock_vec_t        clr;
    rd_req = '0;
    win    = '0;
    wr_hit = '0;
    taken  = '0;
    cond   = '0;
    clr    = '0;
    s_nxt  = s_r;

    // claim reads and releasing writes per lock
    for (int l = 0; l < `SEM_NUM_LOCKS; l++)
    begin
      for (int i = 0; i < N_IF; i++)
      begin
        if (bus_addr[i] == ((l == 0) ? `SEM_OFS_CLAIM0 : `SEM_OFS_CLAIM1))
        begin
          rd_req[l][i] = bus_rd[i];
          wr_hit[l]    = wr_hit[l] | bus_wr[i];
        end
      end
      taken[l] = |s_r.holder[l];
      // lowest set bit wins so the holder stays one-hot
      win[l] = taken[l] ? '0 : (rd_req[l] & (~rd_req[l] + N_IF'(1)));
      if (wr_hit[l])
        s_nxt.holder[l] = '0;
      else if (!taken[l] && |rd_req[l])
        s_nxt.holder[l] = win[l];
    end

    // configuration writes; the highest index wins a same-cycle polarity or mask clash, status clears combine
    for (int i = 0; i < N_IF; i++)
    begin
      if (bus_wr[i])
      begin
        case (bus_addr[i])
          `SEM_OFS_POL:      s_nxt.pol  = bus_wdata[i][1:0];
          `SEM_OFS_IRQ_MASK: s_nxt.mask = bus_wdata[i][1:0];
          `SEM_OFS_IRQ_STAT: clr        = clr | bus_wdata[i][1:0];
          default:           ;
        endcase
      end
    end

    // read data for the cycle after the strobe, zero otherwise
    for (int i = 0; i < N_IF; i++)
    begin
      s_nxt.rdata[i] = '0;
      if (bus_rd[i])
      begin
        case (bus_addr[i])
          `SEM_OFS_CLAIM0:   s_nxt.rdata[i] = `SEM_DATA_W'(win[0][i]);
          `SEM_OFS_CLAIM1:   s_nxt.rdata[i] = `SEM_DATA_W'(win[1][i]);
          `SEM_OFS_HOLD0:    s_nxt.rdata[i] = `SEM_DATA_W'(s_r.holder[0]);
          `SEM_OFS_HOLD1:    s_nxt.rdata[i] = `SEM_DATA_W'(s_r.holder[1]);
          `SEM_OFS_POL:      s_nxt.rdata[i] = `SEM_DATA_W'(s_r.pol);
          `SEM_OFS_IRQ_STAT: s_nxt.rdata[i] = `SEM_DATA_W'(s_r.stat);
          `SEM_OFS_IRQ_MASK: s_nxt.rdata[i] = `SEM_DATA_W'(s_r.mask);
          default:           s_nxt.rdata[i] = '0;
        endcase
      end
    end

    // sticky interrupt status; a live condition beats a clearing write
    for (int l = 0; l < `SEM_NUM_LOCKS; l++)
      cond[l] = s_r.pol[l] ? !taken[l] : taken[l];
    s_nxt.stat = (s_r.stat & ~clr) | cond;
    s_nxt.irq  = |(s_nxt.stat & s_nxt.mask);
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  // asynchronous clear: both holders zero, so both locks come up free;
  // only constants here, the bus ports may still be unknown in reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r        <= '0;  // holders zero: both locks free
      s_r.pol    <= `SEM_POL_RST;
      s_r.mask   <= `SEM_MASK_RST;
      s_r.stat   <= `SEM_STAT_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign bus_rdata = s_r.rdata;
  assign irq       = s_r.irq;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // properties watch interfaces zero and one and the last interface; the ones in
  // between run through exactly the same loop body

  sequence s_free_claim0_by0;
    (s_r.holder[0] == '0) && bus_rd[0] && (bus_addr[0] == `SEM_OFS_CLAIM0)
      && !(|bus_wr);
  endsequence

  sequence s_any_rel0;
    |(bus_wr & {N_IF{1'b1}}) && (bus_addr[0] == `SEM_OFS_CLAIM0) && bus_wr[0];
  endsequence

  property p_claim_grants;
    s_free_claim0_by0 |=> (s_r.holder[0] != '0) && (bus_rdata[0] == 32'h1);
  endproperty
  a_claim_grants: assert property (p_claim_grants)
    else $error("free lock not granted on claim read");

  property p_release;
    s_any_rel0 |=> (s_r.holder[0] == '0) ##1 (s_r.holder[0] == '0 || $past(|bus_rd));
  endproperty
  a_release: assert property (p_release)
    else $error("write did not free lock zero");

  property p_onehot;
    $onehot0(s_r.holder[0]) && $onehot0(s_r.holder[1]);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("holder vector has more than one bit");

  property p_hold_zero;
    (s_r.holder[1] == '0) && bus_rd[1] && (bus_addr[1] == `SEM_OFS_HOLD1)
      |=> bus_rdata[1] == 32'h0;
  endproperty
  a_hold_zero: assert property (p_hold_zero)
    else $error("holder read not zero for a free lock");

  property p_encoding;
    s_free_claim0_by0 |=> s_r.holder[0] == N_IF'(1) ##1
      (!$past(bus_rd[0]) || $past(bus_addr[0]) != `SEM_OFS_HOLD0 || bus_rdata[0] == 32'h1);
  endproperty
  a_encoding: assert property (p_encoding)
    else $error("holder code for interface zero wrong");

  property p_indep;
    (bus_addr[0] == `SEM_OFS_CLAIM1) && bus_wr[0] && (bus_wr == N_IF'(1))
      && !(|bus_rd) |=> $stable(s_r.holder[0]);
  endproperty
  a_indep: assert property (p_indep)
    else $error("lock one access changed lock zero");

  property p_irq_pol;
    !s_r.pol[0] && (s_r.holder[0] != '0) ##1 s_r.mask[0] |-> irq;
  endproperty
  a_irq_pol: assert property (p_irq_pol)
    else $error("taken lock did not raise interrupt");

  property p_priority;
    (s_r.holder[0] == '0) && !(|bus_wr) && (bus_rd[1:0] == 2'b11)
      && (bus_addr[0] == `SEM_OFS_CLAIM0) && (bus_addr[1] == `SEM_OFS_CLAIM0)
      |=> (s_r.holder[0] == N_IF'(1)) && (bus_rdata[1] == 32'h0);
  endproperty
  a_priority: assert property (p_priority)
    else $error("simultaneous claim not resolved to lowest interface");

  // a claim read of a taken lock is refused and leaves the holder alone
  sequence s_taken_claim0_by0;
    (s_r.holder[0] != '0) && bus_rd[0] && (bus_addr[0] == `SEM_OFS_CLAIM0)
      && !(|bus_wr);
  endsequence

  property p_taken_refused;
    s_taken_claim0_by0 |=> (bus_rdata[0] == 32'h0) && $stable(s_r.holder[0]);
  endproperty
  a_taken_refused: assert property (p_taken_refused)
    else $error("claim read of a taken lock was not refused");

  // the last interface frees lock one whatever it writes and whoever holds it
  property p_release_far;
    bus_wr[N_IF-1] && (bus_addr[N_IF-1] == `SEM_OFS_CLAIM1) |=> (s_r.holder[1] == '0);
  endproperty
  a_release_far: assert property (p_release_far)
    else $error("write from the last interface did not free lock one");

  // a holder read reports the holder word as it stood at the read
  property p_hold_report;
    bus_rd[0] && (bus_addr[0] == `SEM_OFS_HOLD0)
      |=> bus_rdata[0] == `SEM_DATA_W'($past(s_r.holder[0]));
  endproperty
  a_hold_report: assert property (p_hold_report)
    else $error("holder read did not report the holder word");

  // release then read back: the holder word must read zero
  sequence s_rel0_by_last;
    bus_wr[N_IF-1] && (bus_addr[N_IF-1] == `SEM_OFS_CLAIM0);
  endsequence

  sequence s_hold0_read;
    bus_rd[0] && (bus_addr[0] == `SEM_OFS_HOLD0);
  endsequence

  property p_rel_then_zero;
    s_rel0_by_last ##1 s_hold0_read |=> bus_rdata[0] == 32'h0;
  endproperty
  a_rel_then_zero: assert property (p_rel_then_zero)
    else $error("holder word not zero after a release");

  // a lone claim from the last interface sets only the top holder bit
  property p_encoding_top;
    (s_r.holder[0] == '0) && !(|bus_wr) && (bus_rd == {1'b1, {(N_IF-1){1'b0}}})
      && (bus_addr[N_IF-1] == `SEM_OFS_CLAIM0)
      |=> s_r.holder[0] == {1'b1, {(N_IF-1){1'b0}}};
  endproperty
  a_encoding_top: assert property (p_encoding_top)
    else $error("holder code for the last interface wrong");

  // claim traffic on lock zero never moves lock one
  property p_indep_one;
    (bus_addr[0] == `SEM_OFS_CLAIM0) && bus_rd[0] && (bus_rd == N_IF'(1))
      && !(|bus_wr) |=> $stable(s_r.holder[1]);
  endproperty
  a_indep_one: assert property (p_indep_one)
    else $error("lock zero access changed lock one");

  // with polarity one a free lock raises the interrupt once unmasked
  property p_irq_free;
    s_r.pol[1] && (s_r.holder[1] == '0) ##1 s_r.mask[1] |-> irq;
  endproperty
  a_irq_free: assert property (p_irq_free)
    else $error("free lock did not raise interrupt");

  // a live condition keeps its status bit even against a clearing write
  property p_set_wins;
    !s_r.pol[0] && (s_r.holder[0] != '0) |=> s_r.stat[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("status bit of a taken lock was lost");

endmodule : sem_core
`default_nettype wire

//--- sim/sem_host.sv
// host partner model: drives the request ports of every interface
`timescale 1ns/1ns
`default_nettype none
module sem_host
#(
  parameter int N = 4
)
(
  input  wire logic               clk,
  output var  logic [N-1:0][7:0]  addr,
  output var  logic [N-1:0][31:0] wdata,
  output var  logic [N-1:0]       wr,
  output var  logic [N-1:0]       rd
);
  // idle buses carry junk so a stale value is never mistaken for a request
  initial
  begin
    wr = '0;
    rd = '0;
    addr = '1;
    wdata = '1;
  end
  // all interfaces request in the same cycle, one-cycle strobes
  task automatic fire(input logic [N-1:0] w, input logic [N-1:0] r,
                      input logic [N-1:0][7:0] a, input logic [N-1:0][31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= '0;
    rd <= '0;
    addr <= ~a;
    wdata <= ~d;
  endtask : fire
endmodule : sem_host
`default_nettype wire

//--- sim/sem_core_test.sv
// self-checking bench for the shared lock block
`timescale 1ns/1ns
`default_nettype none
module sem_core_test;
  import sem_pkg::*;
  localparam int N = 4;
  logic                 clk;
  logic                 rst_n;
  logic                 irq;
  logic [N-1:0][7:0]    a;
  logic [N-1:0][31:0]   d;
  logic [N-1:0][31:0]   rdata;
  logic [N-1:0][31:0]   ex;
  logic [N-1:0][7:0]    ha;
  logic [N-1:0][31:0]   hd;
  logic [N-1:0]         hw;
  logic [N-1:0]         hr;
  logic [N-1:0]         w;
  logic [N-1:0]         r;
  int                   miscompares;
  int                   cmp_count;
  int                   own[2];
  int                   pol;
  int                   msk;
  int                   stat;
  int                   n;
  int                   i;

  sem_host #(.N(N)) host (.clk(clk), .addr(ha), .wdata(hd), .wr(hw), .rd(hr));
  sem_core #(.N_IF(N)) dut_u (.clk(clk), .rst_n(rst_n), .bus_addr(ha), .bus_wdata(hd),
    .bus_wr(hw), .bus_rd(hr), .bus_rdata(rdata), .irq(irq));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // interrupt condition per lock: polarity 0 fires while taken
  function automatic int cnd();
    cnd = 0;
    for (int k = 0; k < 2; k++)
      if (((pol >> k) & 1) ? own[k] < 0 : own[k] >= 0) cnd |= 1 << k;
  endfunction : cnd

  // reference model: replies from the old state, then update
  task automatic step();
    int g[2];
    int wc[2];
    int k;
    int pre;
    g = '{-1, -1};
    wc = '{0, 0};
    // condition of the old state, before this cycle's writes land
    pre = cnd();
    for (int j = 0; j < N; j++)
    begin
      ex[j] = 0;
      k = int'(a[j][3]);
      if (r[j])
        case (a[j])
          8'h00, 8'h08: if (own[k] < 0 && g[k] < 0) begin g[k] = j; ex[j] = 1; end
          8'h04, 8'h0c: ex[j] = own[k] < 0 ? 0 : 1 << own[k];
          8'h10: ex[j] = pol;
          8'h14: ex[j] = stat;
          8'h18: ex[j] = msk;
          default: ;
        endcase
      if (w[j])
        case (a[j])
          8'h00, 8'h08: wc[k] = 1;
          8'h10: pol = d[j] & 3;
          8'h14: stat &= ~d[j];
          8'h18: msk = d[j] & 3;
          default: ;
        endcase
    end
    for (k = 0; k < 2; k++) own[k] = wc[k] ? -1 : (g[k] >= 0 ? g[k] : own[k]);
    stat = (stat & 3) | pre | cnd();
    host.fire(w, r, a, d);
    #1;
    for (int j = 0; j < N; j++) chk("rdata", rdata[j], ex[j]);
    repeat (3) @(posedge clk);
    #1;
    chk("irq", {31'h0, irq}, 32'((stat & msk) != 0));
  endtask : step

  task automatic results();
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  initial
  begin
    rst_n = 1'b0;
    own = '{-1, -1};
    {pol, msk, stat, miscompares, cmp_count} = '0;
    d = '0;
    void'($urandom(29));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // reset values of holder, polarity, status and mask
    w = '0;
    r = '1;
    a = {8'h0c, 8'h10, 8'h14, 8'h18};
    step();
    // all claim lock one together, then each checks the holder word
    a = {N{8'h08}};
    step();
    a = {N{8'h0c}};
    step();
    // release by a non-holder, then everybody sees the lock free
    a = {N{8'h08}};
    w = 4'b0100;
    r = '0;
    step();
    a = {N{8'h0c}};
    w = '0;
    r = '1;
    step();
    for (n = 0; n < 300; n++)
    begin
      for (i = 0; i < N; i++)
      begin
        a[i] = 8'($urandom_range(7) * 4);
        d[i] = $urandom;
        w[i] = 1'($urandom_range(1));
        r[i] = !w[i] && $urandom_range(1);
        if (w[i] && a[i] >= 8'h10 && i < N - 1)
        begin
          w[i] = 1'b0;
          r[i] = 1'b1;
        end
      end
      step();
    end
    results();
  end
endmodule : sem_core_test
`default_nettype wire
